// ==== hdl/rrtlv_map.svh ====
`ifndef RRTLV_MAP_SVH
`define RRTLV_MAP_SVH

// ----------------------------------------
// Tuple type codes
// ----------------------------------------
`define RRT_T_TIMING 8'h01
`define RRT_T_POWER 8'h02
`define RRT_T_FREQ 8'h03
`define RRT_T_EQ 8'h04
`define RRT_T_STATUS 8'h05
`define RRT_T_DS_OVR 8'h06
`define RRT_T_US_OVR 8'h07

// ----------------------------------------
// Fixed value lengths in octets
// ----------------------------------------
`define RRT_L_TIMING 8'h04
`define RRT_L_POWER 8'h01
`define RRT_L_FREQ 8'h02
`define RRT_L_STATUS 8'h01
`define RRT_L_DS_OVR 8'h04
`define RRT_L_US_OVR 8'h01
`define RRT_L_ZERO 8'h00
`define RRT_CNT_LAST 8'h01

// ----------------------------------------
// Ranging status values
// ----------------------------------------
`define RRT_ST_CONTINUE 8'h01
`define RRT_ST_ABORT 8'h02
`define RRT_ST_SUCCESS 8'h03

// ----------------------------------------
// Identifier field
// ----------------------------------------
`define RRT_SID_TOP_ZERO 2'h0

// ----------------------------------------
// Equalizer byte store: 64 taps, 2 entries, 2 octets, plus header
// ----------------------------------------
`define RRT_EQ_AW 9
`define RRT_EQ_PW 10
`define RRT_EQ_DEPTH 10'h200
`define RRT_EQ_PTR_ONE 10'h001

`endif

// ==== hdl/rrtlv_pkg.sv ====
package rrtlv_pkg;

	typedef enum logic [6:0] {
		RRT_S_IDLE = 7'h01,
		RRT_S_SIDL = 7'h02,
		RRT_S_UCID = 7'h04,
		RRT_S_TYPE = 7'h08,
		RRT_S_LEN = 7'h10,
		RRT_S_VAL = 7'h20,
		RRT_S_SKIP = 7'h40
	} rrtlv_state_t;

endpackage

// ==== hdl/rrtlv_coef_mem.sv ====
`timescale 1ns/1ps
`include "rrtlv_map.svh"

module rrtlv_coef_mem (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Write port
	input wire logic we,
	input wire logic [`RRT_EQ_AW-1:0] waddr,
	input wire logic [7:0] wdata,
	// Read port
	input wire logic [`RRT_EQ_AW-1:0] raddr,
	output logic [7:0] rdata_q
);

	logic [7:0] mem [0:(1<<`RRT_EQ_AW)-1];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Array has no reset; only the read register does
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= mem[raddr];
		end
	end

endmodule

// ==== hdl/rrtlv_handler.sv ====
`timescale 1ns/1ps
`include "rrtlv_map.svh"

// Notes on behaviour
// - Responses are accepted at any time; reception keeps no request state.
// - After upstream channel, tuples carry one-octet type and length.
// - Upstream channel in the response is adopted for later transactions.
// - Type 1: four-byte signed timing offset, 6.25 us over 64 units.
// - Type 2: one-byte signed power offset in quarter decibels.
// - Type 3: two-byte signed frequency offset in hertz.
// - Type 5: status byte, 1 continue, 2 abort, 3 success.
// - Type 6: optional four-byte new downstream centre frequency.
// - Type 7: optional one-byte new upstream channel identifier.
// - Type 4: variable length pre-equalizer coefficient data.
// - Up to 64 taps, each a real and imaginary entry, are held.
// - Consecutive type 4 values join into one continuous byte stream.
// - Downstream override: reinitialise, scan given frequency first.
// - Upstream override: reinitialise, first attempt on given channel.
// - Both overrides: reinitialise using both given channel and frequency.
// - On channel change a held temporary identifier is dropped.
// - Identifier is 16 bits, low 14 used, top two zero.
module rrtlv_handler (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Message byte stream, from the identifier onward
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_sop,
	input wire logic rx_eop,
	output logic rx_ready,
	// Modem identifier status
	input wire logic temp_sid_held,
	// Message result
	output logic rsp_done,
	output logic rsp_error,
	output logic [13:0] sid_q,
	output logic sid_bad_q,
	output logic [7:0] ucid_q,
	// Adjustments
	output logic signed [31:0] timing_adj_q,
	output logic timing_upd,
	output logic signed [7:0] power_adj_q,
	output logic power_upd,
	output logic signed [15:0] freq_adj_q,
	output logic freq_upd,
	// Ranging status
	output logic [7:0] rstat_q,
	output logic rstat_upd,
	output logic rstat_continue,
	output logic rstat_abort,
	output logic rstat_success,
	// Equalizer data
	output logic eq_upd,
	output logic [`RRT_EQ_PW-1:0] eq_len_q,
	output logic eq_ovf_q,
	input wire logic [`RRT_EQ_AW-1:0] eq_rd_addr,
	output logic [7:0] eq_rd_data,
	// Channel override
	output logic reinit,
	output logic reinit_ds_valid_q,
	output logic [31:0] reinit_ds_freq_q,
	output logic reinit_us_valid_q,
	output logic [7:0] reinit_us_id_q,
	output logic drop_temp_sid
);

	// ----------------------------------------
	// Decoding helpers
	// ----------------------------------------
	// Fixed-length types with a wrong length are ignored whole
	function automatic logic len_ok(input logic [7:0] t, input logic [7:0] l);
		case (t)
			`RRT_T_TIMING: len_ok = (l == `RRT_L_TIMING);
			`RRT_T_POWER: len_ok = (l == `RRT_L_POWER);
			`RRT_T_FREQ: len_ok = (l == `RRT_L_FREQ);
			`RRT_T_STATUS: len_ok = (l == `RRT_L_STATUS);
			`RRT_T_DS_OVR: len_ok = (l == `RRT_L_DS_OVR);
			`RRT_T_US_OVR: len_ok = (l == `RRT_L_US_OVR);
			default: len_ok = 1'b0;
		endcase
	endfunction

	function automatic logic is_type(input logic [7:0] t,
		input logic [7:0] code);
		is_type = (t == code);
	endfunction

	// ----------------------------------------
	// Parser state
	// ----------------------------------------
	rrtlv_pkg::rrtlv_state_t st_q, st_d, st_pre;
	logic fire;
	logic [7:0] type_q;
	logic [7:0] len_q;
	logic [7:0] cnt_q;
	logic [31:0] shift_q;
	logic [31:0] val;
	logic [7:0] sid_hi_q;
	logic [15:0] stg_sid_q;
	logic [7:0] stg_ucid_q;
	logic tuple_end;
	logic boundary;
	logic done;
	logic bad_end;

	// Stateless reception means the stream is never stalled
	assign rx_ready = 1'b1;
	assign fire = rx_valid;

	always_comb begin
		st_pre = st_q;
		if (fire) begin
			if (rx_sop) begin
				st_pre = rrtlv_pkg::RRT_S_SIDL;
			end else begin
				case (st_q)
					rrtlv_pkg::RRT_S_IDLE: st_pre = rrtlv_pkg::RRT_S_IDLE;
					rrtlv_pkg::RRT_S_SIDL: st_pre = rrtlv_pkg::RRT_S_UCID;
					rrtlv_pkg::RRT_S_UCID: st_pre = rrtlv_pkg::RRT_S_TYPE;
					rrtlv_pkg::RRT_S_TYPE: st_pre = rrtlv_pkg::RRT_S_LEN;
					rrtlv_pkg::RRT_S_LEN: begin
						// one-octet length decides the value span
						if (rx_data == `RRT_L_ZERO) begin
							st_pre = rrtlv_pkg::RRT_S_TYPE;
						end else if (rrtlv_pkg::rrtlv_state_t'(st_q) ==
							rrtlv_pkg::RRT_S_LEN && type_q > `RRT_T_US_OVR) begin
							st_pre = rrtlv_pkg::RRT_S_SKIP;
						end else begin
							st_pre = rrtlv_pkg::RRT_S_VAL;
						end
					end
					rrtlv_pkg::RRT_S_VAL, rrtlv_pkg::RRT_S_SKIP: begin
						if (cnt_q == `RRT_CNT_LAST) begin
							st_pre = rrtlv_pkg::RRT_S_TYPE;
						end
					end
					default: st_pre = rrtlv_pkg::RRT_S_IDLE;
				endcase
			end
		end
		st_d = (fire && rx_eop) ? rrtlv_pkg::RRT_S_IDLE : st_pre;
	end

	assign boundary = (st_pre == rrtlv_pkg::RRT_S_TYPE);
	assign done = fire && rx_eop && boundary;
	assign bad_end = fire && rx_eop && !boundary &&
		(rx_sop || st_q != rrtlv_pkg::RRT_S_IDLE);
	assign tuple_end = fire && !rx_sop &&
		((st_q == rrtlv_pkg::RRT_S_VAL && cnt_q == `RRT_CNT_LAST) ||
		(st_q == rrtlv_pkg::RRT_S_LEN && rx_data == `RRT_L_ZERO &&
		type_q == `RRT_T_EQ));
	assign val = {shift_q[23:0], rx_data};

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= rrtlv_pkg::RRT_S_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	// Header fields and tuple bookkeeping
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sid_hi_q <= 8'h00;
			stg_sid_q <= 16'h0000;
			stg_ucid_q <= 8'h00;
			type_q <= 8'h00;
			len_q <= 8'h00;
			cnt_q <= 8'h00;
			shift_q <= 32'h0000_0000;
		end else if (fire) begin
			if (rx_sop) begin
				sid_hi_q <= rx_data;
			end else begin
				case (st_q)
					rrtlv_pkg::RRT_S_SIDL: stg_sid_q <= {sid_hi_q, rx_data};
					rrtlv_pkg::RRT_S_UCID: stg_ucid_q <= rx_data;
					rrtlv_pkg::RRT_S_TYPE: type_q <= rx_data;
					rrtlv_pkg::RRT_S_LEN: begin
						len_q <= rx_data;
						cnt_q <= rx_data;
						shift_q <= 32'h0000_0000;
					end
					rrtlv_pkg::RRT_S_VAL, rrtlv_pkg::RRT_S_SKIP: begin
						cnt_q <= cnt_q - `RRT_CNT_LAST;
						shift_q <= val;
					end
					default: cnt_q <= cnt_q;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Staging of tuple values until message end
	// ----------------------------------------
	logic [31:0] stg_tim_q;
	logic [7:0] stg_pow_q;
	logic [15:0] stg_frq_q;
	logic [7:0] stg_rst_q;
	logic [31:0] stg_dsf_q;
	logic [7:0] stg_uso_q;
	logic [7:1] seen_q;
	logic [7:1] seen_nx;
	logic [31:0] stg_tim_d;
	logic [7:0] stg_pow_d;
	logic [15:0] stg_frq_d;
	logic [7:0] stg_rst_d;
	logic [31:0] stg_dsf_d;
	logic [7:0] stg_uso_d;
	logic take;

	assign take = tuple_end && len_ok(type_q, len_q);

	// Next values, so a tuple ending on the eop byte still commits
	always_comb begin
		stg_tim_d = stg_tim_q;
		stg_pow_d = stg_pow_q;
		stg_frq_d = stg_frq_q;
		stg_rst_d = stg_rst_q;
		stg_dsf_d = stg_dsf_q;
		stg_uso_d = stg_uso_q;
		if (take) begin
			if (is_type(type_q, `RRT_T_TIMING)) stg_tim_d = val;
			if (is_type(type_q, `RRT_T_POWER)) stg_pow_d = val[7:0];
			if (is_type(type_q, `RRT_T_FREQ)) stg_frq_d = val[15:0];
			if (is_type(type_q, `RRT_T_STATUS)) stg_rst_d = val[7:0];
			if (is_type(type_q, `RRT_T_DS_OVR)) stg_dsf_d = val;
			if (is_type(type_q, `RRT_T_US_OVR)) stg_uso_d = val[7:0];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			stg_tim_q <= 32'h0000_0000;
			stg_pow_q <= 8'h00;
			stg_frq_q <= 16'h0000;
			stg_rst_q <= 8'h00;
			stg_dsf_q <= 32'h0000_0000;
			stg_uso_q <= 8'h00;
		end else begin
			stg_tim_q <= stg_tim_d;
			stg_pow_q <= stg_pow_d;
			stg_frq_q <= stg_frq_d;
			stg_rst_q <= stg_rst_d;
			stg_dsf_q <= stg_dsf_d;
			stg_uso_q <= stg_uso_d;
		end
	end

	// Presence flags, one per defined type
	genvar gi;
	generate
		for (gi = 1; gi <= 7; gi++) begin : g_seen
			assign seen_nx[gi] = !(fire && rx_sop) && (seen_q[gi] ||
				(tuple_end && type_q == 8'(gi) &&
				(type_q == `RRT_T_EQ || len_ok(type_q, len_q))));
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					seen_q[gi] <= 1'b0;
				end else begin
					seen_q[gi] <= seen_nx[gi];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Equalizer byte stream
	// ----------------------------------------
	logic [`RRT_EQ_PW-1:0] eq_ptr_q;
	logic eq_we;
	logic eq_full;
	logic eq_ovf_stg_q;
	logic eq_drop;

	assign eq_full = (eq_ptr_q == `RRT_EQ_DEPTH);
	assign eq_drop = fire && !rx_sop && st_q == rrtlv_pkg::RRT_S_VAL &&
		type_q == `RRT_T_EQ && eq_full;
	// type 4 value bytes go to the store
	// pointer carries over between type 4 tuples
	assign eq_we = fire && !rx_sop && st_q == rrtlv_pkg::RRT_S_VAL &&
		type_q == `RRT_T_EQ && !eq_full;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			eq_ptr_q <= '0;
			eq_ovf_stg_q <= 1'b0;
		end else if (fire && rx_sop) begin
			eq_ptr_q <= '0;
			eq_ovf_stg_q <= 1'b0;
		end else if (eq_we) begin
			eq_ptr_q <= eq_ptr_q + `RRT_EQ_PTR_ONE;
		end else if (eq_drop) begin
			// Bytes past the store are dropped but reported
			eq_ovf_stg_q <= 1'b1;
		end
	end

	// store sized for 64 complex taps
	rrtlv_coef_mem u_mem (
		.clk(clk),
		.arst_n(arst_n),
		.we(eq_we),
		.waddr(eq_ptr_q[`RRT_EQ_AW-1:0]),
		.wdata(rx_data),
		.raddr(eq_rd_addr),
		.rdata_q(eq_rd_data)
	);

	// ----------------------------------------
	// Commit at a clean message end
	// ----------------------------------------
	logic ovr;

	assign ovr = seen_nx[7] || seen_nx[6];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rsp_done <= 1'b0;
			rsp_error <= 1'b0;
			sid_q <= 14'h0000;
			sid_bad_q <= 1'b0;
			ucid_q <= 8'h00;
		end else begin
			rsp_done <= done;
			rsp_error <= bad_end;
			if (done) begin
				sid_q <= stg_sid_q[13:0];
				// top two identifier bits must be zero
				sid_bad_q <= (stg_sid_q[15:14] != `RRT_SID_TOP_ZERO);
				// adopt the responding upstream channel
				// Channel byte itself may carry the eop
				ucid_q <= (st_q == rrtlv_pkg::RRT_S_UCID) ? rx_data :
					stg_ucid_q;
			end
		end
	end

	// Adjustment outputs
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			timing_adj_q <= 32'sh0000_0000;
			power_adj_q <= 8'sh00;
			freq_adj_q <= 16'sh0000;
			rstat_q <= 8'h00;
			timing_upd <= 1'b0;
			power_upd <= 1'b0;
			freq_upd <= 1'b0;
			rstat_upd <= 1'b0;
			rstat_continue <= 1'b0;
			rstat_abort <= 1'b0;
			rstat_success <= 1'b0;
		end else begin
			timing_upd <= done && seen_nx[1];
			power_upd <= done && seen_nx[2];
			freq_upd <= done && seen_nx[3];
			rstat_upd <= done && seen_nx[5];
			rstat_continue <= done && seen_nx[5] &&
				stg_rst_d == `RRT_ST_CONTINUE;
			rstat_abort <= done && seen_nx[5] &&
				stg_rst_d == `RRT_ST_ABORT;
			rstat_success <= done && seen_nx[5] &&
				stg_rst_d == `RRT_ST_SUCCESS;
			if (done && seen_nx[1]) timing_adj_q <= signed'(stg_tim_d);
			if (done && seen_nx[2]) power_adj_q <= signed'(stg_pow_d);
			if (done && seen_nx[3]) freq_adj_q <= signed'(stg_frq_d);
			if (done && seen_nx[5]) rstat_q <= stg_rst_d;
		end
	end

	// Equalizer result
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			eq_upd <= 1'b0;
			eq_len_q <= '0;
			eq_ovf_q <= 1'b0;
		end else begin
			eq_upd <= done && seen_nx[4];
			if (done && seen_nx[4]) begin
				// Count the byte written on the eop edge too
				eq_len_q <= eq_we ? eq_ptr_q + `RRT_EQ_PTR_ONE : eq_ptr_q;
				eq_ovf_q <= eq_ovf_stg_q || eq_drop;
			end
		end
	end

	// Channel override and reinitialisation
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reinit <= 1'b0;
			reinit_ds_valid_q <= 1'b0;
			reinit_ds_freq_q <= 32'h0000_0000;
			reinit_us_valid_q <= 1'b0;
			reinit_us_id_q <= 8'h00;
			drop_temp_sid <= 1'b0;
		end else begin
			reinit <= done && ovr;
			// a held temporary identifier is given up
			drop_temp_sid <= done && ovr && temp_sid_held;
			if (done && ovr) begin
				reinit_ds_valid_q <= seen_nx[6];
				reinit_ds_freq_q <= stg_dsf_d;
				reinit_us_valid_q <= seen_nx[7];
				reinit_us_id_q <= stg_uso_d;
			end
		end
	end

endmodule

// ==== dv/rrtlv_monitor.sv ====
`timescale 1ns/1ps
`include "rrtlv_map.svh"

module rrtlv_monitor (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Byte stream
	input wire logic rx_valid,
	input wire logic rx_eop,
	input wire logic rx_ready,
	// Results
	input wire logic rsp_done,
	input wire logic rsp_error,
	input wire logic [13:0] sid_q,
	input wire logic [7:0] ucid_q,
	input wire logic signed [7:0] power_adj_q,
	input wire logic timing_upd,
	input wire logic power_upd,
	input wire logic freq_upd,
	input wire logic [7:0] rstat_q,
	input wire logic rstat_upd,
	input wire logic rstat_continue,
	input wire logic rstat_abort,
	input wire logic rstat_success,
	input wire logic eq_upd,
	input wire logic [`RRT_EQ_PW-1:0] eq_len_q,
	input wire logic reinit,
	input wire logic reinit_ds_valid_q,
	input wire logic reinit_us_valid_q,
	input wire logic drop_temp_sid
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	AST_READY: assert property (rx_ready)
		else $error("rx_ready low");
	AST_ANSWER: assert property ((rsp_done || rsp_error) |->
		$past(rx_valid && rx_eop)) else $error("answer without eop");
	AST_ONE_VERDICT: assert property (!(rsp_done && rsp_error))
		else $error("done and error together");
	AST_DONE_GAP: assert property (rsp_done |=> !rsp_done [*2])
		else $error("done too close");
	AST_STATUS: assert property (rstat_upd |->
		rstat_continue == (rstat_q == `RRT_ST_CONTINUE) &&
		rstat_abort == (rstat_q == `RRT_ST_ABORT) &&
		rstat_success == (rstat_q == `RRT_ST_SUCCESS))
		else $error("status pulse mismatch");
	AST_COMMIT: assert property ((timing_upd || power_upd ||
		freq_upd || rstat_upd || eq_upd) |-> rsp_done)
		else $error("update without done");
	AST_PWR_HOLD: assert property (!power_upd |->
		$stable(power_adj_q)) else $error("power changed");
	AST_ID_HOLD: assert property (!rsp_done |->
		$stable(ucid_q) && $stable(sid_q)) else $error("id changed");
	AST_REINIT: assert property (reinit |-> rsp_done &&
		(reinit_ds_valid_q || reinit_us_valid_q))
		else $error("reinit without override");
	AST_DROP: assert property (drop_temp_sid |-> reinit)
		else $error("drop without reinit");
	AST_EQ_BOUND: assert property (eq_len_q <= `RRT_EQ_DEPTH)
		else $error("eq length too big");
endmodule

bind rrtlv_handler rrtlv_monitor mon_u (
	.clk(clk), .arst_n(arst_n), .rx_valid(rx_valid), .rx_eop(rx_eop),
	.rx_ready(rx_ready), .rsp_done(rsp_done), .rsp_error(rsp_error),
	.sid_q(sid_q), .ucid_q(ucid_q), .power_adj_q(power_adj_q),
	.timing_upd(timing_upd), .power_upd(power_upd), .freq_upd(freq_upd),
	.rstat_q(rstat_q), .rstat_upd(rstat_upd),
	.rstat_continue(rstat_continue), .rstat_abort(rstat_abort),
	.rstat_success(rstat_success), .eq_upd(eq_upd), .eq_len_q(eq_len_q),
	.reinit(reinit), .reinit_ds_valid_q(reinit_ds_valid_q),
	.reinit_us_valid_q(reinit_us_valid_q), .drop_temp_sid(drop_temp_sid)
);

// ==== dv/rrtlv_headend.sv ====
`timescale 1ns/1ps

module rrtlv_headend (
	// Clock
	input wire logic clk,
	// Response byte stream
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_sop,
	output logic rx_eop
);
	bit slow;

	// Idle data toggles so stale bytes never look valid
	task automatic idle();
		rx_valid = 1'b0;
		rx_sop = 1'b0;
		rx_eop = 1'b0;
		rx_data = ~rx_data;
	endtask

	initial begin
		rx_data = 8'h00;
		slow = 1'b0;
		idle();
	end

	// each call sends one response in octets, with eop on its last byte unless cut is set
	task automatic send(input byte unsigned b[$], input bit cut,
		input bit b2b);
		for (int j = 0; j < b.size(); j++) begin
			if (slow)
				repeat ($urandom_range(2)) begin
					@(negedge clk);
					idle();
				end
			@(negedge clk);
			rx_valid = 1'b1;
			rx_data = b[j];
			rx_sop = j == 0;
			rx_eop = !cut && j == b.size() - 1;
		end
		if (!b2b) begin
			@(negedge clk);
			idle();
		end
	endtask
endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`include "rrtlv_map.svh"

module testbench;
	typedef struct {
		bit ok, tmp;
		int upd, service_identifier, uc, tim, pwr, frq, st, dsf, usid, eqn;
	} rrtlv_exp_t;

	logic clk, arst_n, temp_sid_held, rx_valid, rx_sop, rx_eop, rx_ready;
	logic [7:0] rx_data, ucid_q, rstat_q, eq_rd_data, reinit_us_id_q;
	logic rsp_done, rsp_error, sid_bad_q, timing_upd, power_upd, freq_upd;
	logic rstat_upd, rstat_continue, rstat_abort, rstat_success, eq_upd;
	logic eq_ovf_q, reinit, reinit_ds_valid_q, reinit_us_valid_q;
	logic drop_temp_sid;
	logic [13:0] sid_q;
	logic signed [31:0] timing_adj_q;
	logic signed [7:0] power_adj_q;
	logic signed [15:0] freq_adj_q;
	logic [`RRT_EQ_AW-1:0] eq_rd_addr;
	logic [`RRT_EQ_PW-1:0] eq_len_q;
	logic [31:0] reinit_ds_freq_q;
	int miscompares, n_compared, i;
	int eq_exp;
	bit ovr_exp;
	int flen[8] = '{0, 4, 1, 2, 0, 1, 4, 1};
	byte unsigned m[$];
	int eqb[$];
	rrtlv_exp_t ex[$];
	rrtlv_exp_t cur, sb;

	rrtlv_handler dut_u (
		.clk(clk), .arst_n(arst_n), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_sop(rx_sop), .rx_eop(rx_eop), .rx_ready(rx_ready),
		.temp_sid_held(temp_sid_held), .rsp_done(rsp_done),
		.rsp_error(rsp_error), .sid_q(sid_q), .sid_bad_q(sid_bad_q),
		.ucid_q(ucid_q), .timing_adj_q(timing_adj_q),
		.timing_upd(timing_upd), .power_adj_q(power_adj_q),
		.power_upd(power_upd), .freq_adj_q(freq_adj_q),
		.freq_upd(freq_upd), .rstat_q(rstat_q), .rstat_upd(rstat_upd),
		.rstat_continue(rstat_continue), .rstat_abort(rstat_abort),
		.rstat_success(rstat_success), .eq_upd(eq_upd),
		.eq_len_q(eq_len_q), .eq_ovf_q(eq_ovf_q), .eq_rd_addr(eq_rd_addr),
		.eq_rd_data(eq_rd_data), .reinit(reinit),
		.reinit_ds_valid_q(reinit_ds_valid_q),
		.reinit_ds_freq_q(reinit_ds_freq_q),
		.reinit_us_valid_q(reinit_us_valid_q),
		.reinit_us_id_q(reinit_us_id_q), .drop_temp_sid(drop_temp_sid)
	);

	rrtlv_headend hm_u (.clk(clk), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_sop(rx_sop), .rx_eop(rx_eop));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ----------------------------------------
	// Checking
	// ----------------------------------------
	task automatic chk_val(logic [31:0] got, logic [31:0] exp, string s);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t %s got %h exp %h", $time, s, got, exp);
		end
	endtask

	task automatic chk_pulse(logic got, bit exp, string s);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t %s got %b", $time, s, got);
		end
	endtask

	task automatic report_and_stop();
		$display("compared %0d, mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	always @(negedge clk) begin
		if (arst_n && (rsp_done === 1'b1 || rsp_error === 1'b1)) begin
			sb = rrtlv_exp_t'{default: 0};
			if (ex.size() > 0)
				sb = ex.pop_front();
			ovr_exp = sb.upd[6] || sb.upd[7];
			eq_exp = sb.eqn > `RRT_EQ_DEPTH ? `RRT_EQ_DEPTH : sb.eqn;
			chk_pulse(rsp_done, sb.ok, "done");
			chk_pulse(rsp_error, !sb.ok, "error");
			if (sb.ok) begin
				chk_val(32'(sid_q), sb.service_identifier & 16'h3FFF, "sid");
				chk_pulse(sid_bad_q, sb.service_identifier > 16'h3FFF, "sid top");
				chk_val(32'(ucid_q), sb.uc, "chan");
				chk_val(timing_adj_q, sb.tim, "timing");
				chk_pulse(timing_upd, sb.upd[1], "tim upd");
				chk_val({24'h000000, power_adj_q}, sb.pwr, "power");
				chk_pulse(power_upd, sb.upd[2], "pwr upd");
				chk_val({16'h0000, freq_adj_q}, sb.frq, "freq");
				chk_pulse(freq_upd, sb.upd[3], "frq upd");
				chk_pulse(eq_upd, sb.upd[4], "eq upd");
				chk_val(32'(rstat_q), sb.st, "status");
				chk_pulse(rstat_continue, sb.upd[5] && sb.st == 1, "c");
				chk_pulse(rstat_abort, sb.upd[5] && sb.st == 2, "a");
				chk_pulse(rstat_success, sb.upd[5] && sb.st == 3, "s");
				chk_pulse(reinit, ovr_exp, "reinit");
				chk_pulse(drop_temp_sid, ovr_exp && sb.tmp, "drop");
				if (ovr_exp)
					chk_pulse(reinit_ds_valid_q, sb.upd[6], "ds ok");
				if (ovr_exp)
					chk_pulse(reinit_us_valid_q, sb.upd[7], "us ok");
				if (sb.upd[4])
					chk_val(32'(eq_len_q), eq_exp, "eq len");
				if (sb.upd[4])
					chk_pulse(eq_ovf_q, sb.eqn > eq_exp, "ovf");
				if (sb.upd[6])
					chk_val(reinit_ds_freq_q, sb.dsf, "ds");
				if (sb.upd[7])
					chk_val(32'(reinit_us_id_q), sb.usid, "us");
			end
		end
	end

	// ----------------------------------------
	// Message building and reference parse
	// ----------------------------------------
	task automatic hdr(int service_identifier, int uc);
		m = {};
		m.push_back(8'(service_identifier >> 8));
		m.push_back(8'(service_identifier));
		m.push_back(8'(uc));
	endtask

	task automatic type_length_value_tuple(int t, int l, int v);
		m.push_back(8'(t));
		m.push_back(8'(l));
		for (int j = l - 1; j >= 0; j--)
			m.push_back(8'(v >> (8 * j)));
	endtask

	task automatic predict(bit cut);
		rrtlv_exp_t e;
		int n, p, t, l, v;
		int q4[$];
		e = cur;
		e.upd = 0;
		e.tmp = temp_sid_held;
		n = m.size();
		e.ok = n >= 3;
		if (e.ok) begin
			e.service_identifier = {m[0], m[1]};
			e.uc = m[2];
		end
		p = 3;
		while (e.ok && p < n) begin
			t = m[p];
			l = p + 1 < n ? m[p + 1] : 0;
			e.ok = p + 2 + l <= n;
			v = 0;
			for (int k = p + 2; k < p + 2 + l && k < n; k++) begin
				v = (v << 8) | m[k];
				if (t == 4)
					q4.push_back(m[k]);
			end
			if (e.ok && t > 0 && t < 8 && (t == 4 || l == flen[t])) begin
				e.upd |= 1 << t;
				case (t)
					1: e.tim = v;
					2: e.pwr = v;
					3: e.frq = v;
					5: e.st = v;
					6: e.dsf = v;
					7: e.usid = v;
					default: e.eqn = q4.size();
				endcase
			end
			p = p + 2 + l;
		end
		if (!cut)
			ex.push_back(e);
		if (!cut && e.ok)
			cur = e;
		if (!cut && e.ok && e.upd[4])
			eqb = q4;
	endtask

	task automatic go(bit cut, bit b2b);
		predict(cut);
		hm_u.send(m, cut, b2b);
	endtask

	task automatic drain(string name);
		for (int j = 0; j < 50 && ex.size() > 0; j++)
			@(negedge clk);
		if (ex.size() > 0) begin
			miscompares++;
			$display("BAD %0t no result", $time);
			report_and_stop();
		end else begin
			$display("test %s done", name);
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		arst_n = 1'b0;
		temp_sid_held = 1'b0;
		eq_rd_addr = '0;
		cur = '{default: 0};
		void'($urandom(47));
		repeat (8) @(negedge clk);
		arst_n = 1'b1;
		hdr(16'h0123, 5);
		type_length_value_tuple(2, 1, 8'hFE);
		type_length_value_tuple(5, 1, 3);
		go(0, 0);
		drain("walk");
		for (i = 1; i <= 3; i++) begin
			hdr($urandom, $urandom_range(255));
			type_length_value_tuple(1, 4, $urandom);
			type_length_value_tuple(3, 2, $urandom);
			type_length_value_tuple(5, 1, i);
			go(0, i < 3);
		end
		drain("status");
		hm_u.slow = 1'b1;
		hdr(16'h0100, 9);
		type_length_value_tuple(0, 2, 16'h1234);
		type_length_value_tuple(8, 1, 8'h11);
		type_length_value_tuple(255, 0, 0);
		type_length_value_tuple(2, 2, 16'h0102);
		type_length_value_tuple(6, 3, 24'h000001);
		type_length_value_tuple(1, 4, 32'h00001000);
		go(0, 0);
		hdr(16'h0101, 4);
		go(0, 0);
		drain("skip");
		// eq data opens with a linear header
		hdr(16'h0042, 3);
		m = {m, 8'h04, 8'hFF, 8'h01, 8'h01, 8'h40, 8'h00};
		for (i = 0; i < 251; i++)
			m.push_back(8'($urandom));
		type_length_value_tuple(2, 1, 8'h03);
		m = {m, 8'h04, 8'h2D};
		for (i = 0; i < 45; i++)
			m.push_back(8'($urandom));
		go(0, 0);
		drain("eq");
		for (i = 0; i < eqb.size(); i++) begin
			eq_rd_addr = i[8:0];
			@(negedge clk);
			chk_val(32'(eq_rd_data), eqb[i], "eq byte");
		end
		// three full tuples overrun the store
		hdr(16'h0043, 3);
		for (i = 0; i < 765; i++) begin
			if (i % 255 == 0)
				m = {m, 8'h04, 8'hFF};
			m.push_back(8'($urandom));
		end
		go(0, 0);
		drain("eq overflow");
		for (i = 1; i <= 3; i++) begin
			temp_sid_held = 1'($urandom_range(1));
			// a move carries the init identifier, while joining
			hdr(16'h3FFE, 2);
			if (i[0])
				type_length_value_tuple(6, 4, $urandom);
			if (i[1])
				type_length_value_tuple(7, 1, $urandom_range(255));
			type_length_value_tuple(5, 1, 1);
			go(0, 0);
			drain("override");
		end
		hdr(16'h0007, 1);
		type_length_value_tuple(1, 4, 32'h01020304);
		void'(m.pop_back());
		go(0, 0);
		hdr(16'h0008, 1);
		type_length_value_tuple(2, 1, 8'h05);
		go(1, 1);
		hdr(16'h0009, 4);
		type_length_value_tuple(5, 1, 2);
		go(0, 0);
		drain("cut");
		report_and_stop();
	end
endmodule
